/* File: logic/gpc_pad_slice.v */
// Purpose: one pad slice: function mux, pull, hold latch, sync, edge detect
// Assumes: pad input comes from outside the clock domain
// Notes:   hold freezes configuration and output; power-down kills the enable
`timescale 1ns/10ps
`include "gpc_defs.vh"

module gpc_pad_slice
#(
  parameter NP = `GPC_NUM_PERIPH
)
(
  input  wire                  mclk_in,
  input  wire                  rstn_in,
  input  wire [`GPC_FUNC_W-1:0] func_in,
  input  wire [1:0]            pull_in,
  input  wire                  gpio_out_in,
  input  wire                  gpio_oe_in,
  input  wire [NP-1:0]         per_out_in,
  input  wire [NP-1:0]         per_oe_in,
  input  wire                  hold_in,
  input  wire                  pdown_in,
  input  wire                  pad_in,
  output reg                   pad_out,
  output reg                   pad_oen_out,
  output reg                   pull_up_out,
  output reg                   pull_dn_out,
  output wire                  sync_out,
  output wire                  rise_out,
  output wire                  fall_out
);

  reg [`GPC_FUNC_W-1:0] func_q;
  reg [1:0]             pull_q;
  reg                   do_q;
  reg                   oe_q;
  reg                   meta_q;
  reg                   sync_q;
  reg                   prev_q;
  reg                   last_q;
  reg                   sel_do;
  reg                   sel_oe;
  integer               k;

  // ****************************************
  // function mux
  // ****************************************
  // pick driver from plain I/O or a peripheral
  always @*
  begin
    sel_do = gpio_out_in;
    sel_oe = gpio_oe_in;
    for (k = 0; k < NP; k = k + 1)
    begin
      if (func_q == (`GPC_FUNC_P0 + k[`GPC_FUNC_W-1:0]))
      begin
        sel_do = per_out_in[k];
        sel_oe = per_oe_in[k];
      end
    end
  end

  // ****************************************
  // config and drive state, frozen under hold
  // ****************************************
  // hold keeps selector, pull and drive unchanged
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      func_q <= `GPC_RST_FUNC;
      pull_q <= `GPC_RST_PULL;
      do_q   <= 1'b0;
      oe_q   <= 1'b0;
    end
    else if (pdown_in)
    begin
      oe_q   <= 1'b0;
    end
    else if (!hold_in)
    begin
      func_q <= func_in;
      pull_q <= pull_in;
      do_q   <= sel_do;
      oe_q   <= sel_oe;
    end
  end

  // ****************************************
  // input synchroniser and last-level latch
  // ****************************************
  // two flops, then edge history and kept level
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pad_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      if (!hold_in || oe_q)
        last_q <= oe_q ? do_q : sync_q;
    end
  end

  // ****************************************
  // pad drive, pulls and keeper
  // ****************************************
  // keeper drives last level when pad is floating under hold, except during power-down
  always @*
  begin
    pad_out     = do_q;
    pad_oen_out = ~oe_q;
    if (hold_in && !oe_q && !pdown_in)
    begin
      pad_out     = last_q;
      pad_oen_out = 1'b0;
    end
    pull_up_out = (pull_q == `GPC_PULL_UP);
    pull_dn_out = (pull_q == `GPC_PULL_DOWN);
  end

  assign sync_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;

endmodule

/* File: logic/gpc_defs.vh */
// Purpose: constants for the general-purpose pad controller
// Assumes: 40 MHz clock, seventeen pads
// Notes:   function selector codes and pull encodings live here
//
// Functional notes
// - There are seventeen pads and a per-pad selector picks each one's function, plain I/O included.
// - A pad may instead carry a peripheral such as a two-wire bus, audio serial, serial port, pulse output or infrared line.
// - Each pad on its own may enable a pull-up, a pull-down, or neither.
// - A pad used as input has its level captured into a readable register.
// - An input pad can raise an interrupt, triggered by edge or by level.
// - Each pad is a non-inverting buffer whose driver is gated by its output enable while input stays live.
// - A hold setting freezes each pad's configured state for low power.
// - On power-down every pad output enable is forced and kept inactive.
// - With hold on and nothing driving the pad, the last level is kept.
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// ****************************************
// sizes
// ****************************************
`define GPC_NUM_PADS   17
`define GPC_FUNC_W     3
`define GPC_NUM_PERIPH 6

// ****************************************
// function selector codes
// ****************************************
`define GPC_FUNC_GPIO  3'h0
`define GPC_FUNC_P0    3'h1

// ****************************************
// pull encoding
// ****************************************
`define GPC_PULL_NONE  2'h0
`define GPC_PULL_UP    2'h1
`define GPC_PULL_DOWN  2'h2

// ****************************************
// reset values
// ****************************************
`define GPC_RST_FUNC   3'h0
`define GPC_RST_PULL   2'h0

`endif

/* File: logic/gpc_pad_bank.v */
// Purpose: bank of seventeen general-purpose pads with input capture and irq
// Assumes: one clock, config bits as plain ports
// Notes:   edge events stay pending until the clear strobe for that pad
`timescale 1ns/10ps
`include "gpc_defs.vh"

module gpc_pad_bank
#(
  parameter N  = `GPC_NUM_PADS,
  parameter NP = `GPC_NUM_PERIPH
)
(
  input  wire                     mclk_in,
  input  wire                     rstn_in,
  input  wire [N*`GPC_FUNC_W-1:0] func_sel_in,
  input  wire [2*N-1:0]           pull_sel_in,
  input  wire [N-1:0]             gpio_data_in,
  input  wire [N-1:0]             gpio_oe_in,
  input  wire [N*NP-1:0]          per_data_in,
  input  wire [N*NP-1:0]          per_oe_in,
  input  wire                     hold_in,
  input  wire                     pdown_in,
  input  wire [N-1:0]             irq_en_in,
  input  wire [N-1:0]             irq_level_in,
  input  wire [N-1:0]             irq_pol_in,
  input  wire [N-1:0]             irq_both_in,
  input  wire [N-1:0]             irq_clr_in,
  input  wire [N-1:0]             pad_in,
  output wire [N-1:0]             pad_out,
  output wire [N-1:0]             pad_oen_out,
  output wire [N-1:0]             pull_up_out,
  output wire [N-1:0]             pull_dn_out,
  output reg  [N-1:0]             in_data_out,
  output wire [N-1:0]             per_in_out,
  output reg  [N-1:0]             irq_stat_out,
  output reg                      irq_out
);

  wire [N-1:0] sync_w;
  wire [N-1:0] rise_w;
  wire [N-1:0] fall_w;
  reg  [N-1:0] hit;
  reg  [N-1:0] stat_d;
  integer      i;

  // ****************************************
  // pad slices
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : pads
      gpc_pad_slice #(.NP(NP)) u_slice
      (
        .mclk_in     (mclk_in),
        .rstn_in     (rstn_in),
        .func_in     (func_sel_in[g*`GPC_FUNC_W +: `GPC_FUNC_W]),
        .pull_in     (pull_sel_in[2*g +: 2]),
        .gpio_out_in (gpio_data_in[g]),
        .gpio_oe_in  (gpio_oe_in[g]),
        .per_out_in  (per_data_in[g*NP +: NP]),
        .per_oe_in   (per_oe_in[g*NP +: NP]),
        .hold_in     (hold_in),
        .pdown_in    (pdown_in),
        .pad_in      (pad_in[g]),
        .pad_out     (pad_out[g]),
        .pad_oen_out (pad_oen_out[g]),
        .pull_up_out (pull_up_out[g]),
        .pull_dn_out (pull_dn_out[g]),
        .sync_out    (sync_w[g]),
        .rise_out    (rise_w[g]),
        .fall_out    (fall_w[g])
      );
    end
  endgenerate

  // synchronised input fed to peripherals, input path always live
  assign per_in_out = sync_w;

  // ****************************************
  // trigger detection
  // ****************************************
  // level: pol=1 high, pol=0 low; edge: pol=1 rise, pol=0 fall, both
  always @*
  begin
    for (i = 0; i < N; i = i + 1)
    begin
      hit[i] = irq_en_in[i] & (irq_level_in[i]
             ? ~(sync_w[i] ^ irq_pol_in[i])
             : (irq_both_in[i] ? (rise_w[i] | fall_w[i])
               : (irq_pol_in[i] ? rise_w[i] : fall_w[i])));
    end
    // set beats clear in the same cycle
    stat_d = (irq_stat_out & ~irq_clr_in) | hit;
  end

  // ****************************************
  // capture and sticky status
  // ****************************************
  // sample inputs, hold pending events, drive irq
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      in_data_out  <= {N{1'b0}};
      irq_stat_out <= {N{1'b0}};
      irq_out      <= 1'b0;
    end
    else
    begin
      in_data_out  <= sync_w;
      irq_stat_out <= stat_d;
      irq_out      <= |stat_d;
    end
  end

endmodule

/* File: testbench/gpc_pad_props.sv */
// Purpose: port checks for the pad bank
// Assumes: bound into gpc_pad_bank
// Notes:   pad 0 stands for every pad
`timescale 1ns/10ps
module gpc_pad_props
#(
  parameter N = 17
)
(
  input wire           mclk_in,
  input wire           rstn_in,
  input wire [3*N-1:0] func_sel_in,
  input wire [2*N-1:0] pull_sel_in,
  input wire [N-1:0]   gpio_data_in,
  input wire [N-1:0]   gpio_oe_in,
  input wire           hold_in,
  input wire           pdown_in,
  input wire [N-1:0]   irq_level_in,
  input wire [N-1:0]   irq_clr_in,
  input wire [N-1:0]   pad_in,
  input wire [N-1:0]   pad_out,
  input wire [N-1:0]   pad_oen_out,
  input wire [N-1:0]   pull_up_out,
  input wire [N-1:0]   in_data_out,
  input wire [N-1:0]   irq_stat_out,
  input wire           irq_out
);
  // config live only outside hold and power-down
  wire run = !hold_in && !pdown_in;
  wire hk  = hold_in && !pdown_in;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  chk_pdown_oe: assert property (pdown_in |=> &pad_oen_out)
    else $error("oe live in power-down");
  // selector is registered, so plain drive needs two settled cycles
  chk_cfg_drive: assert property (run && $past(run) &&
    func_sel_in[2:0] == 3'h0 && $past(func_sel_in[2:0]) == 3'h0 |=>
    pad_oen_out[0] == !$past(gpio_oe_in[0]) &&
    (pad_oen_out[0] || pad_out[0] == $past(gpio_data_in[0])))
    else $error("plain drive wrong");
  chk_pull_dec: assert property (run |=>
    pull_up_out[0] == ($past(pull_sel_in[1:0]) == 2'h1))
    else $error("pull decode wrong");
  chk_in_capture: assert property ($stable(pad_in)[*4] |->
    in_data_out == pad_in)
    else $error("input capture wrong");
  chk_irq_sum: assert property (irq_out == |irq_stat_out)
    else $error("irq not or of status");
  chk_irq_stay: assert property (irq_stat_out[0] && !irq_clr_in[0] |=>
    irq_stat_out[0])
    else $error("pending lost");
  chk_irq_clear: assert property ($stable(pad_in[0])[*4] ##0
    (irq_clr_in[0] && !irq_level_in[0]) |=> !irq_stat_out[0])
    else $error("clear ignored");
  chk_hold_freeze: assert property (hk[*3] |-> $stable(pad_out) &&
    $stable(pad_oen_out) && $stable(pull_up_out))
    else $error("state moved in hold");
  chk_keeper_on: assert property (hk[*3] |-> pad_oen_out == '0)
    else $error("keeper not driving");
  cover property (irq_clr_in[0] && irq_stat_out[0]);
  cover property (hk[*3]);
  cover property (pdown_in ##1 &pad_oen_out);
endmodule
bind gpc_pad_bank gpc_pad_props #(.N(N)) u_gpc_pad_props
(
  .mclk_in, .rstn_in, .func_sel_in, .pull_sel_in, .gpio_data_in,
  .gpio_oe_in, .hold_in, .pdown_in, .irq_level_in, .irq_clr_in, .pad_in,
  .pad_out, .pad_oen_out, .pull_up_out, .in_data_out, .irq_stat_out, .irq_out
);

/* File: testbench/gpc_pad_model.sv */
// Purpose: circuitry outside the pads
// Assumes: bank wins over far driver
// Notes:   an undriven pad without pull toggles each cycle
`timescale 1ns/10ps
module gpc_pad_model
(
  input  wire        mclk_in,
  input  wire [16:0] pad_out,
  input  wire [16:0] pad_oen_out,
  input  wire [16:0] pull_up_out,
  input  wire [16:0] pull_dn_out,
  input  wire [16:0] ext_en_in,
  input  wire [16:0] ext_val_in,
  output reg  [16:0] lvl_out
);
  reg [16:0] flt_q = 17'h00000;
  // floating lines never show a stale level
  always @(posedge mclk_in)
    flt_q <= ~flt_q;
  // wire level: bank, far driver, pull, float
  always @*
    for (int g = 0; g < 17; g++)
      lvl_out[g] = !pad_oen_out[g] ? pad_out[g] :
        ext_en_in[g] ? ext_val_in[g] :
        pull_up_out[g] ? 1'b1 :
        pull_dn_out[g] ? 1'b0 : flt_q[g];
endmodule

/* File: testbench/gpc_pad_bank_bench.sv */
// Purpose: directed test of the pad bank
// Assumes: inputs change at the falling edge
// Notes:   pad 0 edge irq, pad 2 level irq
`timescale 1ns/10ps
module gpc_pad_bank_bench;
  reg         mclk_in = 1'b0;
  reg         rstn_in = 1'b0;
  reg         hold_in = 1'b0;
  reg         pdown_in = 1'b0;
  reg [50:0]  func_sel_in = 51'h0;
  reg [33:0]  pull_sel_in = 34'h0;
  reg [101:0] per_data_in = 102'h0;
  reg [101:0] per_oe_in = 102'h0;
  reg [16:0]  gpio_data_in = 17'h0, gpio_oe_in = 17'h0, irq_en_in = 17'h0;
  reg [16:0]  irq_level_in = 17'h0, irq_pol_in = 17'h0, irq_clr_in = 17'h0;
  reg [16:0]  ext_en = 17'h0, ext_val = 17'h0, irq_both_in = 17'h0;
  wire [16:0] pad_in, pad_out, pad_oen_out, pull_up_out, pull_dn_out;
  wire [16:0] in_data_out, per_in_out, irq_stat_out;
  wire        irq_out;
  integer     num_errors = 0, checked = 0, cyc = 0, g;
  gpc_pad_bank u_gpc_pad_bank
  (
    .mclk_in, .rstn_in, .func_sel_in, .pull_sel_in, .gpio_data_in,
    .gpio_oe_in, .per_data_in, .per_oe_in, .hold_in, .pdown_in,
    .irq_en_in, .irq_level_in, .irq_pol_in, .irq_both_in,
    .irq_clr_in, .pad_in, .pad_out, .pad_oen_out, .pull_up_out,
    .pull_dn_out, .in_data_out, .per_in_out, .irq_stat_out, .irq_out
  );
  gpc_pad_model u_gpc_pad_model
  (
    .mclk_in, .pad_out, .pad_oen_out, .pull_up_out, .pull_dn_out,
    .ext_en_in(ext_en), .ext_val_in(ext_val), .lvl_out(pad_in)
  );
  // clock and hang guard
  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  task step(input integer n);
    repeat (n) @(negedge mclk_in);
  endtask
  task check(input [16:0] got, input [16:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // directed sequence
  initial
  begin
    step(8);
    check(pad_oen_out, 17'h1FFFF);
    rstn_in = 1'b1;
    gpio_oe_in = 17'h1FFFF;
    gpio_data_in = 17'h1A5C3;
    step(1);
    check(pad_oen_out, 17'h0);
    check(pad_out, 17'h1A5C3);
    gpio_oe_in = 17'h0;
    ext_en = 17'h1FFFF;
    ext_val = 17'h0F0F1;
    step(4);
    check(in_data_out, 17'h0F0F1);
    check(per_in_out, 17'h0F0F1);
    for (g = 0; g < 17; g = g + 1)
    begin
      func_sel_in[3*g +: 3] = 3'(g % 6 + 1);
      per_data_in[6*g +: 6] = {6{~g[0]}} ^ (6'h1 << (g % 6));
    end
    per_oe_in = {102{1'b1}};
    // code 7 on the top pad falls back to plain i/o
    func_sel_in[50:48] = 3'h7;
    // registered selector: the new function drives two edges later
    step(2);
    check(pad_oen_out, 17'h10000);
    check(pad_out, 17'h1AAAA);
    func_sel_in = 51'h0;
    for (g = 0; g < 4; g = g + 1)
    begin
      pull_sel_in = {17{g[1:0]}};
      step(1);
      check(pull_up_out, {17{g == 1}});
      check(pull_dn_out, {17{g == 2}});
    end
    pull_sel_in = 34'h0;
    ext_val = 17'h0;
    // let earlier pad edges drain before arming interrupts
    step(4);
    irq_en_in = 17'h00005;
    irq_level_in = 17'h00004;
    irq_pol_in = 17'h00001;
    step(4);
    check(irq_stat_out, 17'h00004);
    ext_val = 17'h00007;
    step(4);
    check(irq_stat_out, 17'h00005);
    irq_clr_in = 17'h00005;
    step(1);
    irq_clr_in = 17'h0;
    step(1);
    check({16'h0, irq_out}, 17'h0);
    ext_val = 17'h0;
    step(4);
    check(irq_stat_out, 17'h00004);
    // both edges on pad 1, falling on pad 3, high level on pad 4
    irq_en_in = 17'h0001A;
    irq_level_in = 17'h00010;
    irq_pol_in = 17'h00010;
    irq_both_in = 17'h00002;
    irq_clr_in = 17'h1FFFF;
    step(1);
    irq_clr_in = 17'h0;
    check(irq_stat_out, 17'h0);
    ext_val = 17'h0000A;
    step(4);
    check(irq_stat_out, 17'h00002);
    ext_val = 17'h00010;
    step(4);
    check(irq_stat_out, 17'h0001A);
    gpio_oe_in = 17'h000FF;
    gpio_data_in = 17'h00055;
    ext_val = 17'h12300;
    step(4);
    hold_in = 1'b1;
    step(1);
    gpio_oe_in = 17'h0;
    pull_sel_in = {17{2'h1}};
    ext_en = 17'h0;
    step(4);
    check(pad_oen_out, 17'h0);
    check(pad_out, 17'h12355);
    pdown_in = 1'b1;
    step(2);
    check(pad_oen_out, 17'h1FFFF);
    hold_in = 1'b0;
    pdown_in = 1'b0;
    step(2);
    check(pull_up_out, 17'h1FFFF);
    end_of_test;
  end
endmodule
